/* servo_stop_params.svh */
// offsets, field positions, reset values and counts of the stop selector
`ifndef SERVO_STOP_PARAMS_SVH
`define SERVO_STOP_PARAMS_SVH

// register byte offsets on the wishbone slave
`define OFS_POWER_LOSS    8'h00
`define OFS_SERVO_OFF     8'h04
`define OFS_PROTECTIVE    8'h08
`define OFS_OVERTRAVEL    8'h0C
`define OFS_ESTOP_TORQUE  8'h10
`define OFS_STANDSTILL    8'h14
`define OFS_STATUS        8'h18

// reset values of the settings
`define RST_STOP_CODE     4'h0
`define RST_OVT_CODE      2'h0
`define RST_ESTOP_TORQUE  9'h000
`define RST_STANDSTILL    16'h0010

// stop code boundaries
`define CODE_HOLD_FIRST   4'h4
`define CODE_HOLD_LAST    4'h7
`define CODE_ESTOP_BRAKE  4'h8
`define CODE_ESTOP_FREE   4'h9
`define OVT_CODE_ESTOP    2'h2
`define OVT_CODE_FREE     2'h1

// status register field positions
`define ST_BRAKE_BIT      0
`define ST_GATE_BIT       1
`define ST_TLIM_BIT       2
`define ST_STATE_LSB      4
`define ST_CAUSE_LSB      8
`define ST_OVT_LSB        12
`define ST_OVT_PEND_LSB   14

// qualify cycles for standstill detection
`define STANDSTILL_CYCLES 4

`endif

/* servo_stop_pkg.sv */
// types and stop code decoding for the stop selector
package servo_stop_pkg;
  `include "servo_stop_params.svh"

  // braking action during deceleration
  typedef enum logic [1:0] {ACT_BRAKE, ACT_FREE, ACT_ESTOP} stop_act_t;
  // stop sequence state
  typedef enum logic [1:0] {ST_RUN, ST_DECEL, ST_STOPPED} stop_state_t;
  // trigger that started the stop
  typedef enum logic [2:0]
  {
    CS_NONE, CS_POWER, CS_ALARM, CS_OVERTRAVEL, CS_SERVO_OFF
  } stop_cause_t;

  // decoded stop plan
  typedef struct packed {
    stop_act_t decel;
    logic      afterBrake;
    logic      clearDev;
  } stop_plan_t;

  // maps a ten-value stop code onto its plan; out of range acts as 0
  function automatic stop_plan_t decode_stop(input logic [3:0] code);
    stop_plan_t p;
    p.decel      = code[0] ? ACT_FREE : ACT_BRAKE;
    p.afterBrake = !code[1];
    p.clearDev   = (code < `CODE_HOLD_FIRST);
    if (code == `CODE_ESTOP_BRAKE || code == `CODE_ESTOP_FREE)
    begin
      p.decel      = ACT_ESTOP;
      p.afterBrake = (code == `CODE_ESTOP_BRAKE);
      p.clearDev   = 1'b1;
    end
    else if (code > `CODE_ESTOP_FREE)
    begin
      p.decel      = ACT_BRAKE;
      p.afterBrake = 1'b1;
      p.clearDev   = 1'b1;
    end
    return p;
  endfunction : decode_stop

endpackage : servo_stop_pkg

/* standstill_detector.sv */
// flags standstill once speed stays below threshold for some cycles
`timescale 1ns/1ps
`include "servo_stop_params.svh"
module standstill_detector
  import servo_stop_pkg::*;
#(
  parameter int SPEED_W = 16,
  parameter int QUAL    = `STANDSTILL_CYCLES
)
(
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic [SPEED_W-1:0] speedMag,
  input  wire logic [SPEED_W-1:0] threshold,
  output logic                    standstill
);
  logic [3:0] qualCnt_ff;    // consecutive slow cycles
  logic       still_ff;      // qualified standstill

  // count slow cycles, restart on any fast sample
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      qualCnt_ff <= 4'h0;
      still_ff   <= 1'b0;
    end
    else if (speedMag < threshold)
    begin
      if (qualCnt_ff < 4'(QUAL))
        qualCnt_ff <= qualCnt_ff + 4'h1;
      still_ff <= (qualCnt_ff >= 4'(QUAL - 1));
    end
    else
    begin
      qualCnt_ff <= 4'h0;
      still_ff   <= 1'b0;
    end
  end

  assign standstill = still_ff;
endmodule : standstill_detector

/* deviation_clear_ctrl.sv */
// drives clear and hold of the position deviation counter
`timescale 1ns/1ps
module deviation_clear_ctrl
  import servo_stop_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic stopActive,
  input  wire logic clearSel,
  input  wire logic alarmActive,
  output logic      devClear,
  output logic      devHold
);
  logic alarmPrev_ff;   // alarm level one cycle ago
  logic clear_ff;       // clear request to counter
  logic hold_ff;        // hold request to counter

  // clear while stopping with clearSel set, or once as the alarm itself clears
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      alarmPrev_ff <= 1'b0;
      clear_ff     <= 1'b0;
      hold_ff      <= 1'b0;
    end
    else
    begin
      alarmPrev_ff <= alarmActive;
      clear_ff     <= (stopActive && clearSel) ||
                      (alarmPrev_ff && !alarmActive);
      hold_ff      <= stopActive && !clearSel;
    end
  end

  assign devClear = clear_ff;
  assign devHold  = hold_ff;
endmodule : deviation_clear_ctrl

/* servo_stop_sequence_selector.sv */
// stop sequence selector top with wishbone settings registers
`timescale 1ns/1ps
`include "servo_stop_params.svh"
module servo_stop_sequence_selector
  import servo_stop_pkg::*;
#(
  parameter int   SPEED_W         = 16,
  parameter logic BRAKE_DEFAULT_ON = 1'b1
)
(
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic               wbCyc,
  input  wire logic               wbStb,
  input  wire logic               wbWe,
  input  wire logic [7:0]         wbAdr,
  input  wire logic [3:0]         wbSel,
  input  wire logic [31:0]        wbDatW,
  output logic      [31:0]        wbDatR,
  output logic                    wbAck,
  input  wire logic               mainPowerLost,
  input  wire logic               servo_enable_input,
  input  wire logic               alarmActive,
  input  wire logic               alarmImmediate,
  input  wire logic               forward_travel_inhibit,
  input  wire logic               reverseTravelInhibit,
  input  wire logic [1:0]         storedOvertravelSetting,
  input  wire logic [SPEED_W-1:0] speedMag,
  output logic                    short_circuit_brake,
  output logic                    gateOff,
  output logic                    torqueLimitActive,
  output logic      [8:0]         torqueLimitValue,
  output logic                    devClear,
  output logic                    devHold
);
  // settings registers
  logic [3:0]         power_loss_stop_setting_ff;
  logic [3:0]         servo_off_stop_setting_ff;
  logic [3:0]         protective_stop_setting_ff;
  logic [1:0]         overtravel_stop_setting_ff;  // pending copy
  logic [8:0]         emergency_stop_torque_setting_ff;
  logic [SPEED_W-1:0] standstillThr_ff;
  logic [1:0]         appliedOvt_ff;               // in-force copy
  logic               ovtCaptured_ff;              // caught after reset
  // bus side
  logic               wbAck_ff;
  logic [31:0]        wbDatR_ff;
  logic               wbReq;
  logic [31:0]        rdMux;
  // sequencer
  stop_state_t        state_ff;
  stop_state_t        nxt_state;
  stop_cause_t        cause_ff;
  stop_cause_t        nxt_cause;
  stop_plan_t         plan_ff;
  stop_plan_t         nxt_plan;
  logic               anyTrigger;
  logic               overtravel;
  logic               standstill;
  // output flops
  logic               brake_ff;
  logic               gateOff_ff;
  logic               tlim_ff;
  logic [8:0]         tlimVal_ff;

  assign overtravel = forward_travel_inhibit || reverseTravelInhibit;
  assign anyTrigger = mainPowerLost || alarmActive || overtravel ||
                      !servo_enable_input;
  assign wbReq      = wbCyc && wbStb && !wbAck_ff;

  // settings writes with byte lanes
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      power_loss_stop_setting_ff       <= `RST_STOP_CODE;
      servo_off_stop_setting_ff        <= `RST_STOP_CODE;
      protective_stop_setting_ff       <= `RST_STOP_CODE;
      overtravel_stop_setting_ff       <= `RST_OVT_CODE;
      emergency_stop_torque_setting_ff <= `RST_ESTOP_TORQUE;
      standstillThr_ff                 <= SPEED_W'(`RST_STANDSTILL);
    end
    else if (wbCyc && wbStb && wbWe && wbAck_ff) // lands with ack
    begin
      unique case (wbAdr)
        `OFS_POWER_LOSS:
          if (wbSel[0]) power_loss_stop_setting_ff <= wbDatW[3:0];
        `OFS_SERVO_OFF:
          if (wbSel[0]) servo_off_stop_setting_ff <= wbDatW[3:0];
        `OFS_PROTECTIVE:
          if (wbSel[0]) protective_stop_setting_ff <= wbDatW[3:0];
        `OFS_OVERTRAVEL:
          if (wbSel[0]) overtravel_stop_setting_ff <= wbDatW[1:0];
        `OFS_ESTOP_TORQUE:
        begin
          if (wbSel[0])
            emergency_stop_torque_setting_ff[7:0] <= wbDatW[7:0];
          if (wbSel[1])
            emergency_stop_torque_setting_ff[8] <= wbDatW[8];
        end
        `OFS_STANDSTILL:
        begin
          if (wbSel[0]) standstillThr_ff[7:0] <= wbDatW[7:0];
          if (wbSel[1]) standstillThr_ff[15:8] <= wbDatW[15:8];
        end
        default: ; // status and unmapped: write ignored
      endcase
    end
  end

  // overtravel setting in force is caught once after reset release
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      appliedOvt_ff  <= `RST_OVT_CODE;
      ovtCaptured_ff <= 1'b0;
    end
    else if (!ovtCaptured_ff)
    begin
      appliedOvt_ff  <= storedOvertravelSetting;
      ovtCaptured_ff <= 1'b1;
    end
  end

  // read data multiplexer
  always_comb
  begin
    rdMux = 32'h0000_0000;
    unique case (wbAdr)
      `OFS_POWER_LOSS:   rdMux[3:0] = power_loss_stop_setting_ff;
      `OFS_SERVO_OFF:    rdMux[3:0] = servo_off_stop_setting_ff;
      `OFS_PROTECTIVE:   rdMux[3:0] = protective_stop_setting_ff;
      `OFS_OVERTRAVEL:   rdMux[1:0] = overtravel_stop_setting_ff;
      `OFS_ESTOP_TORQUE: rdMux[8:0] = emergency_stop_torque_setting_ff;
      `OFS_STANDSTILL:   rdMux[15:0] = standstillThr_ff;
      `OFS_STATUS:
      begin
        rdMux[`ST_BRAKE_BIT] = brake_ff;
        rdMux[`ST_GATE_BIT]  = gateOff_ff;
        rdMux[`ST_TLIM_BIT]  = tlim_ff;
        rdMux[`ST_STATE_LSB +: 2] = state_ff;
        rdMux[`ST_CAUSE_LSB +: 3] = cause_ff;
        rdMux[`ST_OVT_LSB +: 2]   = appliedOvt_ff;
        rdMux[`ST_OVT_PEND_LSB +: 2] = overtravel_stop_setting_ff;
      end
      default: rdMux = 32'h0000_0000; // unmapped reads zero
    endcase
  end

  // one-cycle acknowledge for every access, mapped or not
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wbAck_ff  <= 1'b0;
      wbDatR_ff <= 32'h0000_0000;
    end
    else
    begin
      wbAck_ff  <= wbReq;
      wbDatR_ff <= wbReq ? rdMux : 32'h0000_0000;
    end
  end

  // pick highest priority trigger and its plan
  always_comb
  begin
    nxt_cause = CS_NONE;
    nxt_plan  = decode_stop(servo_off_stop_setting_ff);
    if (mainPowerLost)
    begin
      nxt_cause = CS_POWER;
      nxt_plan  = decode_stop(power_loss_stop_setting_ff);
    end
    else if (alarmActive)
    begin
      nxt_cause = CS_ALARM;
      nxt_plan  = decode_stop(protective_stop_setting_ff);
      // immediate-stop alarms on codes 4 to 7 run operation A: emergency decel
      if (protective_stop_setting_ff >= `CODE_HOLD_FIRST &&
          protective_stop_setting_ff <= `CODE_HOLD_LAST &&
          alarmImmediate)
        nxt_plan.decel = ACT_ESTOP;
      nxt_plan.clearDev = 1'b0;  // clear waits for alarm reset
    end
    else if (overtravel)
    begin
      nxt_cause           = CS_OVERTRAVEL;
      nxt_plan.afterBrake = 1'b0;
      nxt_plan.clearDev   = 1'b0;
      if (appliedOvt_ff == `OVT_CODE_ESTOP)
        nxt_plan.decel = ACT_ESTOP;
      else if (appliedOvt_ff == `OVT_CODE_FREE)
        nxt_plan.decel = ACT_FREE;
      else
        nxt_plan.decel = ACT_BRAKE;
    end
    else if (!servo_enable_input)
      nxt_cause = CS_SERVO_OFF;
  end

  // stop sequence state machine
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_RUN:     if (anyTrigger) nxt_state = ST_DECEL;
      ST_DECEL:
        if (!anyTrigger)     nxt_state = ST_RUN;
        else if (standstill) nxt_state = ST_STOPPED;
      ST_STOPPED: if (!anyTrigger) nxt_state = ST_RUN;
    endcase
  end

  // state and latched plan
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= ST_RUN;
      cause_ff <= CS_NONE;
      plan_ff  <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      if (state_ff == ST_RUN && anyTrigger)
      begin
        cause_ff <= nxt_cause;
        plan_ff  <= nxt_plan;
      end
      else if (nxt_state == ST_RUN)
        cause_ff <= CS_NONE;
    end
  end

  // brake, gate and torque limit outputs
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      brake_ff   <= BRAKE_DEFAULT_ON;
      gateOff_ff <= 1'b1;
      tlim_ff    <= 1'b0;
      tlimVal_ff <= `RST_ESTOP_TORQUE;
    end
    else
    begin
      tlimVal_ff <= emergency_stop_torque_setting_ff;
      unique case (state_ff)
        ST_RUN:
        begin
          brake_ff   <= 1'b0;
          gateOff_ff <= 1'b0;
          tlim_ff    <= 1'b0;
        end
        ST_DECEL:
        begin
          brake_ff   <= (plan_ff.decel == ACT_BRAKE);
          gateOff_ff <= (plan_ff.decel != ACT_ESTOP);
          tlim_ff    <= (plan_ff.decel == ACT_ESTOP);
        end
        ST_STOPPED:
        begin
          brake_ff   <= plan_ff.afterBrake;
          gateOff_ff <= 1'b1;
          tlim_ff    <= 1'b0;
        end
      endcase
    end
  end

  // standstill qualification
  standstill_detector #(.SPEED_W(SPEED_W)) u_still
  (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .speedMag   (speedMag),
    .threshold  (standstillThr_ff),
    .standstill (standstill)
  );

  // deviation counter clear and hold
  deviation_clear_ctrl u_dev
  (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .stopActive  (state_ff != ST_RUN),
    .clearSel    (plan_ff.clearDev),
    .alarmActive (alarmActive),
    .devClear    (devClear),
    .devHold     (devHold)
  );

  assign wbAck               = wbAck_ff;
  assign wbDatR              = wbDatR_ff;
  assign short_circuit_brake = brake_ff;
  assign gateOff             = gateOff_ff;
  assign torqueLimitActive   = tlim_ff;
  assign torqueLimitValue    = tlimVal_ff;

  // checks on the control clock, quiet while reset is held except chk_brake_default
  default clocking chkClk @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  chk_pwrloss_free: assert property (
    (state_ff == ST_RUN && mainPowerLost &&
     power_loss_stop_setting_ff == 4'h3)
    |-> ##2 (!brake_ff && gateOff_ff))
    else $error("power loss code 3 did not free-run");
  chk_pwrloss_hold: assert property (
    (state_ff == ST_RUN && mainPowerLost &&
     power_loss_stop_setting_ff == 4'h5) |-> ##2 devHold)
    else $error("power loss code 5 did not hold deviation");
  chk_srvoff_estop: assert property (
    (state_ff == ST_RUN && !servo_enable_input && !mainPowerLost &&
     !alarmActive && !overtravel && servo_off_stop_setting_ff == 4'h8)
    |-> ##2 (tlim_ff && !brake_ff && devClear))
    else $error("servo-off code 8 not emergency stop");
  chk_estop_torque: assert property (
    tlim_ff |-> tlimVal_ff == $past(emergency_stop_torque_setting_ff))
    else $error("torque limit differs from setting");
  chk_prot_split: assert property (
    (state_ff == ST_RUN && alarmActive && !mainPowerLost &&
     protective_stop_setting_ff == 4'h5)
    |-> ##2 (tlim_ff == $past(alarmImmediate, 2)))
    else $error("protective A/B split wrong");
  chk_alarm_clear: assert property (
    $fell(alarmActive) |=> devClear)
    else $error("deviation not cleared at alarm clear");
  chk_ovt_torque: assert property (
    (state_ff == ST_RUN && overtravel && !mainPowerLost &&
     !alarmActive && appliedOvt_ff == `OVT_CODE_ESTOP)
    |-> ##2 tlim_ff)
    else $error("overtravel code 2 without torque limit");
  chk_ovt_frozen: assert property (
    ovtCaptured_ff |=> $stable(appliedOvt_ff))
    else $error("overtravel setting changed without power-on");
  chk_trigger_stop: assert property (
    (state_ff == ST_RUN && anyTrigger) |=> state_ff == ST_DECEL)
    else $error("trigger did not start a stop");
  chk_brake_default: assert property (
    disable iff (1'b0) rst |-> brake_ff == BRAKE_DEFAULT_ON)
    else $error("brake not in default during reset");
  chk_standstill: assert property (
    (state_ff == ST_DECEL && anyTrigger && standstill)
    |=> state_ff == ST_STOPPED ##1 (brake_ff == plan_ff.afterBrake))
    else $error("standstill did not enter after-stop");
  cov_estop: cover property (@(posedge ref_clk) disable iff (rst)
    state_ff == ST_DECEL && plan_ff.decel == ACT_ESTOP);
  cov_stopped: cover property (@(posedge ref_clk) disable iff (rst)
    state_ff == ST_STOPPED ##1 state_ff == ST_RUN);
  cov_alarm: cover property (@(posedge ref_clk) disable iff (rst)
    cause_ff == CS_ALARM && state_ff == ST_STOPPED);
endmodule : servo_stop_sequence_selector

/* motor_speed_model.sv */
// motor and power stage model that feeds speed back to the selector
`timescale 1ns/1ps
module motor_speed_model
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        brakeOn,
  input  wire logic        gateOff,
  input  wire logic        torqueLim,
  input  wire logic [15:0] target,
  output logic      [15:0] speedMag
);
  logic [15:0] speed_ff;  // present shaft speed
  logic [15:0] nxt_speed; // speed after this cycle
  logic [15:0] step;      // loss of speed per cycle

  // shorted windings stop fastest, a coasting motor slowest
  always_comb
  begin
    step = brakeOn ? 16'h0040 : (gateOff ? 16'h0010 : 16'h0020);
    if (brakeOn || gateOff || torqueLim)
      nxt_speed = (speed_ff > step) ? speed_ff - step : 16'h0000;
    else
      nxt_speed = (speed_ff < target) ? speed_ff + 16'h0040 : target;
  end

  // speed state, at rest after reset
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      speed_ff <= 16'h0000;
    else
      speed_ff <= nxt_speed;
  end

  assign speedMag = speed_ff;
endmodule : motor_speed_model

/* servo_stop_sequence_selector_test.sv */
// self-checking bench for the stop sequence selector
`timescale 1ns/1ps
module servo_stop_sequence_selector_test
  import servo_stop_pkg::*;
;
  logic        ref_clk = 1'b0;  // control clock
  logic        rst = 1'b0;      // async reset, raised by do_reset
  logic        wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [7:0]  wbAdr = 8'h00;
  logic [3:0]  wbSel = 4'h0;
  logic [31:0] wbDatW = 32'h0, wbDatR, rd;
  logic        wbAck;
  logic        mainPowerLost = 1'b0, servo_enable_input = 1'b1;
  logic        alarmActive = 1'b0, alarmImmediate = 1'b0;
  logic        forward_travel_inhibit = 1'b0, reverseTravelInhibit = 1'b0;
  logic [1:0]  storedOvt = 2'h2;  // overtravel code kept in memory
  logic [15:0] speedMag;
  logic        short_circuit_brake, gateOff, torqueLimitActive;
  logic        devClear, devHold;
  logic [8:0]  torqueLimitValue, tq;  // tq: torque setting in force
  logic [4:0]  outs;                  // stop outputs as one vector
  int          bad_count = 0, compares = 0;

  assign outs = {short_circuit_brake, gateOff, torqueLimitActive,
                 devClear, devHold};
  // 25 MHz clock
  always #20 ref_clk = ~ref_clk;

  servo_stop_sequence_selector i_servo_stop_sequence_selector
  (
    .ref_clk(ref_clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW),
    .wbDatR(wbDatR), .wbAck(wbAck), .mainPowerLost(mainPowerLost),
    .servo_enable_input(servo_enable_input), .alarmActive(alarmActive),
    .alarmImmediate(alarmImmediate),
    .forward_travel_inhibit(forward_travel_inhibit),
    .reverseTravelInhibit(reverseTravelInhibit),
    .storedOvertravelSetting(storedOvt), .speedMag(speedMag),
    .short_circuit_brake(short_circuit_brake), .gateOff(gateOff),
    .torqueLimitActive(torqueLimitActive),
    .torqueLimitValue(torqueLimitValue), .devClear(devClear),
    .devHold(devHold)
  );

  motor_speed_model i_motor_speed_model
  (
    .ref_clk(ref_clk), .rst(rst), .brakeOn(short_circuit_brake),
    .gateOff(gateOff), .torqueLim(torqueLimitActive),
    .target(16'h0FA0), .speedMag(speedMag)
  );

  // expected {brake, gateOff, tlim, clear, hold}; trig 1 power,
  // 2 alarm, 3/5 fwd/rev overtravel, 4 servo-off
  function automatic logic [4:0] exp_out(int trig, int code, int imm,
                                         bit stopped);
    int         act;  // 0 brake, 1 free-run, 2 emergency
    bit         aft;  // brake after the stop
    bit         clr;  // deviation cleared
    logic [2:0] o;
    act = code % 2;
    aft = (code % 4) < 2;
    clr = (code < 4) || (code > 7);
    if (code > 7)
    begin
      act = 2;
      aft = (code == 8);
    end
    if (trig == 2)
    begin
      clr = 1'b0;
      if (imm != 0 && code > 3 && code < 8)
        act = 2;
    end
    if (trig == 3 || trig == 5)
    begin
      act = code;
      aft = 1'b0;
      clr = 1'b0;
    end
    if (stopped)
      o = aft ? 3'b110 : 3'b010;
    else
      o = (act == 0) ? 3'b110 : ((act == 1) ? 3'b010 : 3'b001);
    return {o, clr, !clr};
  endfunction : exp_out

  // compares the stop outputs under a mask
  task automatic chk_out(string what, logic [4:0] exp, logic [4:0] msk);
    compares++;
    if ((outs & msk) !== (exp & msk))
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp & msk,
               outs & msk);
    end
  endtask : chk_out

  // compares a register or counted value
  task automatic chk_reg(string what, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_reg

  // one classic wishbone cycle; read data lands in rd
  task automatic wb_xfer(logic we, logic [7:0] adr, logic [31:0] dat,
                         logic [3:0] sel);
    int n;
    @(posedge ref_clk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= adr;
    wbDatW <= dat;
    wbSel  <= sel;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (wbAck !== 1'b1 && n < 20);
    rd = wbDatR;
    chk_reg("bus acknowledge", 32'h1, 32'(wbAck === 1'b1));
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask : wb_xfer

  // ten-cycle reset with a given stored overtravel code
  task automatic do_reset(logic [1:0] stored);
    @(posedge ref_clk);
    rst       <= 1'b1;
    storedOvt <= stored;
    repeat (5) @(posedge ref_clk);
    #1;
    chk_out("reset outputs", 5'b11000, 5'h1F);
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    tq = 9'h000;
  endtask : do_reset

  // raises one trigger, checks decel, stop, release
  task automatic run_stop(int trig, int code, int imm);
    logic [4:0] msk;
    int         n;
    int         cnt;
    msk = (trig == 2) ? 5'h1E : 5'h1F;
    n = 0;
    while (speedMag < 16'h0FA0 && n < 300)
    begin
      @(posedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    mainPowerLost          <= (trig == 1);
    alarmActive            <= (trig == 2);
    alarmImmediate         <= (imm != 0);
    forward_travel_inhibit <= (trig == 3);
    reverseTravelInhibit   <= (trig == 5);
    servo_enable_input     <= (trig != 4);
    repeat (3) @(posedge ref_clk);
    #1;
    chk_out("decel outputs", exp_out(trig, code, imm, 0), msk);
    chk_reg("torque value", 32'(tq), 32'(torqueLimitValue));
    n = 0;
    while (speedMag >= 16'h0010 && n < 1000)
    begin
      @(posedge ref_clk);
      n++;
    end
    repeat (8) @(posedge ref_clk);
    #1;
    chk_out("stopped outputs", exp_out(trig, code, imm, 1), msk);
    @(posedge ref_clk);
    mainPowerLost          <= 1'b0;
    alarmActive            <= 1'b0;
    forward_travel_inhibit <= 1'b0;
    reverseTravelInhibit   <= 1'b0;
    servo_enable_input     <= 1'b1;
    cnt = 0;
    repeat (5)
    begin
      @(posedge ref_clk);
      #1;
      cnt += (devClear === 1'b1);
    end
    if (trig == 2)
      chk_reg("clear pulses", 32'h1, 32'(cnt));
    chk_out("run outputs", 5'h00, 5'h1F);
    $display("test stop trigger %0d code %0d done", trig, code);
  endtask : run_stop

  // prints the counts and the verdict, ends the run
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  // cuts a hang short
  initial
  begin
    repeat (80000) @(posedge ref_clk);
    bad_count++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    wrap_up();
  end

  // main sequence
  initial
  begin
    int          i;
    logic [31:0] wv[6];
    int          rstVal[$];
    int          regMask[$];
    rstVal  = '{0, 0, 0, 0, 0, 16};
    regMask = '{15, 15, 15, 3, 511, 65535};
    wv[0] = $urandom(32'hB5B7);
    do_reset(2'h2);
    for (i = 0; i < 6; i++)
    begin
      wb_xfer(1'b0, 8'(i * 4), 32'h0, 4'hF);
      chk_reg("reset value", 32'(rstVal[i]), rd);
      wv[i] = $urandom() & regMask[i];
      wb_xfer(1'b1, 8'(i * 4), wv[i], 4'hF);
      wb_xfer(1'b0, 8'(i * 4), 32'h0, 4'hF);
      chk_reg("readback", wv[i], rd);
    end
    wb_xfer(1'b1, 8'h00, 32'hFFFFFFFF, 4'h0);
    wb_xfer(1'b0, 8'h00, 32'h0, 4'hF);
    chk_reg("unselected lanes", wv[0], rd);
    wb_xfer(1'b0, 8'h1C, 32'h0, 4'hF);
    chk_reg("unmapped read", 32'h0, rd);
    wb_xfer(1'b1, 8'h18, 32'hFFFFFFFF, 4'hF);
    wb_xfer(1'b0, 8'h18, 32'h0, 4'hF);
    chk_reg("status", (wv[3] << 14) | 32'h2000, rd);
    wb_xfer(1'b1, 8'h14, 32'h10, 4'h3);
    $display("test registers done");
    // every code on power loss, then on servo-off
    for (i = 0; i < 20; i++)
    begin
      tq = 9'($urandom());
      wb_xfer(1'b1, 8'h10, 32'(tq), 4'h3);
      wb_xfer(1'b1, (i < 10) ? 8'h00 : 8'h04, 32'(i % 10), 4'h1);
      run_stop((i < 10) ? 1 : 4, i % 10, 0);
    end
    // protective trips, with and without immediate stop
    wb_xfer(1'b1, 8'h08, 32'h5, 4'h1);
    run_stop(2, 5, 1);
    run_stop(2, 5, 0);
    wb_xfer(1'b1, 8'h08, 32'h0, 4'h1);
    run_stop(2, 0, 0);
    // overtravel: register change waits for the next power-on
    wb_xfer(1'b1, 8'h0C, 32'h1, 4'h1);
    run_stop(3, 2, 0);
    do_reset(2'h1);
    wb_xfer(1'b0, 8'h18, 32'h0, 4'hF);
    chk_reg("applied overtravel", 32'h1000, rd & 32'h3000);
    run_stop(5, 1, 0);
    do_reset(2'h0);
    run_stop(3, 0, 0);
    wrap_up();
  end
endmodule : servo_stop_sequence_selector_test
